// File: tsscm_pkg.sv
// package: constants and types for the two-speed start-up and clock monitor
package tsscm_pkg;

  // ----------------------------------------------------------------------
  // register map (avalon word addresses, byte offset = 4 * word)
  // ----------------------------------------------------------------------
  localparam logic [3:0] TSSCM_ADDR_CONFIG      = 4'h0;
  localparam logic [3:0] TSSCM_ADDR_OSC_CONTROL = 4'h1;
  localparam logic [3:0] TSSCM_ADDR_IRQ_STATUS  = 4'h2;
  localparam logic [3:0] TSSCM_ADDR_IRQ_ENABLE  = 4'h3;
  localparam logic [3:0] TSSCM_ADDR_IRQ_CLEAR   = 4'h4;
  localparam logic [3:0] TSSCM_ADDR_CONTROL     = 4'h5;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int TSSCM_CFG_SWITCHOVER_BIT = 0;
  localparam int TSSCM_CFG_MONITOR_BIT    = 1;
  localparam int TSSCM_OSC_SCS_LSB        = 0;
  localparam int TSSCM_OSC_STATUS_BIT     = 3;
  localparam int TSSCM_OSC_FAIL_BIT       = 4;
  localparam int TSSCM_CTL_SLEEP_BIT      = 0;
  localparam int TSSCM_CTL_FAILCLR_BIT    = 1;
  localparam int TSSCM_IRQ_SWITCH_BIT     = 0;
  localparam int TSSCM_IRQ_FAIL_BIT       = 1;
  localparam int TSSCM_IRQ_STARTUP_BIT    = 2;

  // ----------------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0]  TSSCM_CONFIG_RESET = 2'h0;
  localparam logic [1:0]  TSSCM_SCS_RESET    = 2'h0;
  localparam logic [2:0]  TSSCM_IRQ_RESET    = 3'h0;
  localparam int          TSSCM_SAMPLE_DIV   = 64;
  localparam logic [5:0]  TSSCM_DIV_LAST     = 6'(TSSCM_SAMPLE_DIV - 1);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSSCM_SCS_PRIMARY  = 2'h0,
    TSSCM_SCS_TIMER1   = 2'h1,
    TSSCM_SCS_INTERNAL = 2'h2,
    TSSCM_SCS_INT_ALT  = 2'h3
  } tsscm_scs_t;

  typedef enum logic [1:0] {
    TSSCM_ST_PRIMARY  = 2'b00,
    TSSCM_ST_STARTUP  = 2'b01,
    TSSCM_ST_FAILSAFE = 2'b11,
    TSSCM_ST_SLEEP    = 2'b10
  } tsscm_state_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tsscm_bus_req_t;

  typedef struct packed {
    logic        switchover_enable;
    logic        clock_monitor_enable;
  } tsscm_config_t;

endpackage : tsscm_pkg

// File: tsscm_monitor.sv
// clock monitor latch and sample-clock divider
`timescale 1ns/1ns
`default_nettype none
module tsscm_monitor
  import tsscm_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic rc_tick_in,
  input  wire logic mon_fall_in,
  output logic      sample_edge_out,
  output logic      fail_out
);

  logic [5:0] div_reg;
  logic       latch_reg;

  // ----------------------------------------------------------------------
  // sample clock: rc ticks divided by 64
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !enable_in) begin
      div_reg <= 6'h00;
    end else if (rc_tick_in) begin
      div_reg <= (div_reg == TSSCM_DIV_LAST) ? 6'h00 : div_reg + 6'h01;
    end
  end

  assign sample_edge_out = enable_in && rc_tick_in && (div_reg == TSSCM_DIV_LAST);

  // ----------------------------------------------------------------------
  // latch: set by monitored falling edge, cleared by sample edge
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !enable_in) begin
      latch_reg <= 1'b1;
    end else if (mon_fall_in) begin
      latch_reg <= 1'b1;
    end else if (sample_edge_out) begin
      latch_reg <= 1'b0;
    end
  end

  // a fall coinciding with the sample edge counts as activity
  assign fail_out = sample_edge_out && !latch_reg && !mon_fall_in;

endmodule : tsscm_monitor
`default_nettype wire

// File: tsscm_top.sv
// two-speed start-up controller with fail-safe clock monitor
// Overview of operation
// - two-speed start-up acts only while the switchover enable bit is set
// - resets and sleep wakes select the internal oscillator when enabled
// - start-up timer expiry switches to primary run mode automatically
// - other mode changes ignore switchover; source switches at once, run mode waits for primary ready
// - clock-select writes and sleep requests accepted during internal start-up
// - status bit 3 reads one on primary clock, zero on internal
// - with monitor enabled, primary failure switches to internal oscillator
// - internal oscillator forced running while monitor is enabled
// - sample clock is internal oscillator divided by 64
// - latch set by monitored falling edge, cleared by sample rising edge
`timescale 1ns/1ns
`default_nettype none
module tsscm_top
  import tsscm_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        power_up_done_in,
  input  wire logic        ost_done_in,
  input  wire logic        wake_in,
  input  wire logic        rc_osc_in,
  input  wire logic        primary_clk_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             use_internal_clk_out,
  output logic             internal_rc_run_out,
  output logic             primary_run_mode_out,
  output logic             sleep_out,
  output logic             irq_out
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic       rc_prev_reg;
  logic       pri_prev_reg;
  logic       pwr_ok;
  logic       ost_ok;
  logic       wake_ok;
  logic       rc_tick;
  logic       pri_fall;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {primary_clk_in, rc_osc_in, wake_in, ost_done_in, power_up_done_in};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rc_prev_reg  <= 1'b0;
      pri_prev_reg <= 1'b0;
    end else begin
      rc_prev_reg  <= sync2_reg[3];
      pri_prev_reg <= sync2_reg[4];
    end
  end

  assign pwr_ok   = sync2_reg[0];
  assign ost_ok   = sync2_reg[1];
  assign wake_ok  = sync2_reg[2];
  assign rc_tick  = sync2_reg[3] && !rc_prev_reg;
  assign pri_fall = !sync2_reg[4] && pri_prev_reg;

  // ----------------------------------------------------------------------
  // avalon slave
  // ----------------------------------------------------------------------
  tsscm_bus_req_t req;
  tsscm_config_t  config_reg;
  logic [1:0]     scs_reg;
  logic [2:0]     irq_status_reg;
  logic [2:0]     irq_enable_reg;
  logic           fail_flag_reg;
  logic           ack_reg;
  logic           wr_go;
  logic           rd_go;

  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
    hit = (addr == target);
  endfunction

  assign req = '{address: avs_address_in, read: avs_read_in, write: avs_write_in, writedata: avs_writedata_in};

  // one wait cycle per access, then the access completes
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (req.read || req.write) && !ack_reg;
    end
  end

  assign avs_waitrequest_out = (req.read || req.write) && !ack_reg;
  assign wr_go = req.write && ack_reg;
  // load read data in the wait cycle so it stands at the completing edge
  assign rd_go = req.read && !ack_reg;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      config_reg <= TSSCM_CONFIG_RESET;
    end else if (wr_go && hit(req.address, TSSCM_ADDR_CONFIG)) begin
      config_reg.switchover_enable    <= req.writedata[TSSCM_CFG_SWITCHOVER_BIT];
      config_reg.clock_monitor_enable <= req.writedata[TSSCM_CFG_MONITOR_BIT];
    end
  end

  // clock-select stays writable in every state, start-up included
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      scs_reg <= TSSCM_SCS_RESET;
    end else if (wr_go && hit(req.address, TSSCM_ADDR_OSC_CONTROL)) begin
      scs_reg <= req.writedata[TSSCM_OSC_SCS_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_enable_reg <= TSSCM_IRQ_RESET;
    end else if (wr_go && hit(req.address, TSSCM_ADDR_IRQ_ENABLE)) begin
      irq_enable_reg <= req.writedata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // clock source state machine
  // ----------------------------------------------------------------------
  tsscm_state_t state_reg;
  tsscm_state_t state_next;
  logic         boot_pending_reg;
  logic         sleep_req;
  logic         fail_clr;
  logic         mon_fail;
  logic         sample_edge;
  logic         want_internal;

  assign sleep_req = wr_go && hit(req.address, TSSCM_ADDR_CONTROL) && req.writedata[TSSCM_CTL_SLEEP_BIT];
  assign fail_clr  = wr_go && hit(req.address, TSSCM_ADDR_CONTROL) && req.writedata[TSSCM_CTL_FAILCLR_BIT];
  assign want_internal = (scs_reg == TSSCM_SCS_INTERNAL) || (scs_reg == TSSCM_SCS_INT_ALT);

  // start-up decision waits for the power-up timer after reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      boot_pending_reg <= 1'b1;
    end else if (pwr_ok) begin
      boot_pending_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TSSCM_ST_PRIMARY: begin
        if (boot_pending_reg && pwr_ok && config_reg.switchover_enable && !ost_ok) begin
          state_next = TSSCM_ST_STARTUP;
        end else if (mon_fail) begin
          state_next = TSSCM_ST_FAILSAFE;
        end else if (sleep_req) begin
          state_next = TSSCM_ST_SLEEP;
        end
      end
      TSSCM_ST_STARTUP: begin
        if (sleep_req) begin
          state_next = TSSCM_ST_SLEEP;
        end else if (ost_ok) begin
          state_next = TSSCM_ST_PRIMARY;
        end
      end
      TSSCM_ST_FAILSAFE: begin
        if (fail_clr) begin
          state_next = TSSCM_ST_PRIMARY;
        end else if (sleep_req) begin
          state_next = TSSCM_ST_SLEEP;
        end
      end
      TSSCM_ST_SLEEP: begin
        if (wake_ok) begin
          if (config_reg.switchover_enable && !ost_ok) begin
            state_next = TSSCM_ST_STARTUP;
          end else begin
            state_next = TSSCM_ST_PRIMARY;
          end
        end
      end
      default: begin
        state_next = TSSCM_ST_PRIMARY;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg <= TSSCM_ST_PRIMARY;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // fail-safe monitor
  // ----------------------------------------------------------------------
  logic monitoring;

  // only meaningful while the primary is the source being watched
  assign monitoring = config_reg.clock_monitor_enable && (state_reg == TSSCM_ST_PRIMARY) && !boot_pending_reg;

  tsscm_monitor u_monitor (
    .core_clk_in     (core_clk_in),
    .reset_in        (reset_in),
    .enable_in       (monitoring),
    .rc_tick_in      (rc_tick),
    .mon_fall_in     (pri_fall),
    .sample_edge_out (sample_edge),
    .fail_out        (mon_fail)
  );

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      fail_flag_reg <= 1'b0;
    end else if (mon_fail) begin
      fail_flag_reg <= 1'b1;
    end else if (fail_clr) begin
      fail_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status: set wins over clear
  // ----------------------------------------------------------------------
  logic [2:0] irq_events;
  logic [2:0] irq_clear;

  assign irq_events[TSSCM_IRQ_SWITCH_BIT]  = (state_reg == TSSCM_ST_STARTUP) && (state_next == TSSCM_ST_PRIMARY);
  assign irq_events[TSSCM_IRQ_FAIL_BIT]    = mon_fail;
  assign irq_events[TSSCM_IRQ_STARTUP_BIT] = (state_reg != TSSCM_ST_STARTUP) && (state_next == TSSCM_ST_STARTUP);
  assign irq_clear = (wr_go && hit(req.address, TSSCM_ADDR_IRQ_CLEAR)) ? req.writedata[2:0] : 3'h0;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_status_reg <= TSSCM_IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
    end
  end

  assign irq_out = |(irq_status_reg & irq_enable_reg);

  // ----------------------------------------------------------------------
  // clock outputs
  // ----------------------------------------------------------------------
  logic on_primary;

  // outside start-up, fail-safe and sleep the software selection stands, so
  // a plain mode change switches its source at once; run mode waits for ost
  assign on_primary = (state_reg == TSSCM_ST_PRIMARY) && !want_internal && !boot_pending_reg;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      use_internal_clk_out <= 1'b1;
      primary_run_mode_out <= 1'b0;
      sleep_out            <= 1'b0;
    end else begin
      use_internal_clk_out <= !on_primary;
      primary_run_mode_out <= on_primary && ost_ok;
      sleep_out            <= (state_next == TSSCM_ST_SLEEP);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      internal_rc_run_out <= 1'b1;
    end else begin
      internal_rc_run_out <= config_reg.clock_monitor_enable || (state_next != TSSCM_ST_PRIMARY) || want_internal;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (rd_go) begin
      avs_readdata_out <= 32'h00000000;
      case (req.address)
        TSSCM_ADDR_CONFIG: begin
          avs_readdata_out[TSSCM_CFG_SWITCHOVER_BIT] <= config_reg.switchover_enable;
          avs_readdata_out[TSSCM_CFG_MONITOR_BIT]    <= config_reg.clock_monitor_enable;
        end
        TSSCM_ADDR_OSC_CONTROL: begin
          avs_readdata_out[TSSCM_OSC_SCS_LSB +: 2]  <= scs_reg;
          avs_readdata_out[TSSCM_OSC_STATUS_BIT]    <= !use_internal_clk_out;
          avs_readdata_out[TSSCM_OSC_FAIL_BIT]      <= fail_flag_reg;
        end
        TSSCM_ADDR_IRQ_STATUS: begin
          avs_readdata_out[2:0] <= irq_status_reg;
        end
        TSSCM_ADDR_IRQ_ENABLE: begin
          avs_readdata_out[2:0] <= irq_enable_reg;
        end
        default: begin
          avs_readdata_out <= 32'h00000000;
        end
      endcase
    end
  end

endmodule : tsscm_top
`default_nettype wire

// File: tsscm_props.sv
// checker: port-level properties of the two-speed start-up controller
`timescale 1ns/1ns
`default_nettype none
module tsscm_props
  import tsscm_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic        power_up_done_in,
  input wire logic        ost_done_in,
  input wire logic        wake_in,
  input wire logic        rc_osc_in,
  input wire logic        primary_clk_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        use_internal_clk_out,
  input wire logic        internal_rc_run_out,
  input wire logic        primary_run_mode_out,
  input wire logic        sleep_out,
  input wire logic        irq_out
);
  // ----------------------------------------------------------------------
  // shadow of software settings and primary stall count
  // ----------------------------------------------------------------------
  logic       sw_en_q;
  logic       mon_en_q;
  logic [2:0] irq_en_q;
  logic [9:0] stall_q;
  logic       prim_q;
  wire logic  wr_done = avs_write_in && !avs_waitrequest_out;
  wire logic  rd_done = avs_read_in && !avs_waitrequest_out;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sw_en_q  <= 1'b0;
      mon_en_q <= 1'b0;
      irq_en_q <= 3'h0;
    end else if (wr_done && avs_address_in == TSSCM_ADDR_CONFIG) begin
      sw_en_q  <= avs_writedata_in[TSSCM_CFG_SWITCHOVER_BIT];
      mon_en_q <= avs_writedata_in[TSSCM_CFG_MONITOR_BIT];
    end else if (wr_done && avs_address_in == TSSCM_ADDR_IRQ_ENABLE) begin
      irq_en_q <= avs_writedata_in[2:0];
    end
  end

  // cycles since the primary line last moved; saturates so it never wraps
  always_ff @(posedge core_clk_in) begin
    prim_q <= primary_clk_in;
    if (reset_in || sleep_out || prim_q != primary_clk_in) begin
      stall_q <= 10'h000;
    end else if (stall_q != 10'h3FF) begin
      stall_q <= stall_q + 10'h001;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  chk_bus_one_wait: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus request not answered after one wait");
  chk_reset_state: assert property (disable iff (1'b0) reset_in |=> use_internal_clk_out &&
    internal_rc_run_out && !primary_run_mode_out && !sleep_out) else $error("bad state after reset");
  chk_sleep_taken: assert property (wr_done && avs_address_in == TSSCM_ADDR_CONTROL &&
    avs_writedata_in[TSSCM_CTL_SLEEP_BIT] |-> ##[1:4] sleep_out) else $error("sleep request ignored");
  chk_wake_internal: assert property (sleep_out && $rose(wake_in) && sw_en_q |->
    ##[1:8] (use_internal_clk_out && !sleep_out)) else $error("wake did not start on internal clock");
  chk_timer_switch: assert property ($rose(ost_done_in) && sw_en_q && !sleep_out |->
    ##[1:8] (!use_internal_clk_out && primary_run_mode_out)) else $error("no switch to primary run");
  chk_run_mode_clock: assert property ($rose(primary_run_mode_out) |->
    ##[0:2] !use_internal_clk_out) else $error("primary run mode while on internal clock");
  chk_status_bit: assert property (rd_done && avs_address_in == TSSCM_ADDR_OSC_CONTROL &&
    $stable(use_internal_clk_out) |-> avs_readdata_out[TSSCM_OSC_STATUS_BIT] == !use_internal_clk_out)
    else $error("start-up status bit disagrees with clock source");
  chk_fail_bound: assert property (mon_en_q && !sleep_out && stall_q == 10'h2BC |->
    use_internal_clk_out) else $error("stopped primary not replaced by internal clock");
  chk_rc_kept: assert property (mon_en_q && $past(mon_en_q, 2) |-> internal_rc_run_out)
    else $error("internal oscillator not kept running");
  chk_fail_late: assert property ($rose(irq_out) && irq_en_q == 3'h2 |-> stall_q >= 10'h0C8)
    else $error("clock failure flagged before a full sample period");
endmodule // tsscm_props

bind tsscm_top tsscm_props u_props (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .power_up_done_in(power_up_done_in), .ost_done_in(ost_done_in), .wake_in(wake_in),
  .rc_osc_in(rc_osc_in), .primary_clk_in(primary_clk_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .use_internal_clk_out(use_internal_clk_out), .internal_rc_run_out(internal_rc_run_out),
  .primary_run_mode_out(primary_run_mode_out), .sleep_out(sleep_out), .irq_out(irq_out));
`default_nettype wire

// File: tsscm_osc_model.sv
// partner model: primary crystal oscillator with its start-up timer
`timescale 1ns/1ns
`default_nettype none
module tsscm_osc_model #(
  parameter int HALF      = 3,
  parameter int OST_EDGES = 40
) (
  input  wire logic core_clk_in,
  input  wire logic run_in,
  input  wire logic fault_in,
  output logic      osc_out = 1'b0,
  output logic      ost_done_out = 1'b0
);
  int ph_reg;
  int ost_reg;

  // stopped crystal stands low; a fault freezes the line where it is
  always_ff @(posedge core_clk_in) begin
    if (!run_in) begin
      ph_reg       <= 0;
      ost_reg      <= 0;
      osc_out      <= 1'b0;
      ost_done_out <= 1'b0;
    end else if (!fault_in) begin
      if (ph_reg == HALF - 1) begin
        ph_reg  <= 0;
        osc_out <= ~osc_out;
      end else begin
        ph_reg <= ph_reg + 1;
      end
      if (ost_reg == OST_EDGES) begin
        ost_done_out <= 1'b1;
      end else if (ph_reg == HALF - 1 && osc_out) begin
        ost_reg <= ost_reg + 1;
      end
    end
  end
endmodule // tsscm_osc_model
`default_nettype wire

// File: tsscm_tb.sv
// testbench: bus-driven scenarios for the two-speed start-up controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tsscm_pkg::*;
  logic           core_clk_in = 1'b0;
  logic           reset_in = 1'b1;
  logic           power_up_done_in = 1'b0;
  logic           wake_in = 1'b0;
  logic           rc_osc_in = 1'b0;
  logic           rc_ph = 1'b0;
  logic           osc_on = 1'b0;
  logic           osc_stop = 1'b0;
  tsscm_bus_req_t req = '0;
  logic           primary_clk;
  logic           ost_done;
  logic [31:0]    readdata;
  logic [31:0]    rd;
  logic           waitrequest;
  logic           use_internal;
  logic           rc_run;
  logic           primary_run;
  logic           sleep_st;
  logic           irq;
  int             errors = 0;
  int             n_checks = 0;
  int             cycles = 0;

  always #50 core_clk_in = ~core_clk_in;

  // rc source at a quarter of the core rate, so one sample is 256 cycles
  always @(posedge core_clk_in) begin
    rc_ph <= ~rc_ph;
    if (rc_ph) begin
      rc_osc_in <= ~rc_osc_in;
    end
  end

  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      results();
    end
  end

  tsscm_top DUT (.core_clk_in(core_clk_in), .reset_in(reset_in), .power_up_done_in(power_up_done_in),
    .ost_done_in(ost_done), .wake_in(wake_in), .rc_osc_in(rc_osc_in), .primary_clk_in(primary_clk),
    .avs_address_in(req.address), .avs_read_in(req.read), .avs_write_in(req.write),
    .avs_writedata_in(req.writedata), .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest),
    .use_internal_clk_out(use_internal), .internal_rc_run_out(rc_run),
    .primary_run_mode_out(primary_run), .sleep_out(sleep_st), .irq_out(irq));

  tsscm_osc_model #(.HALF(3), .OST_EDGES(40)) u_osc (.core_clk_in(core_clk_in),
    .run_in(osc_on && !sleep_st), .fault_in(osc_stop), .osc_out(primary_clk), .ost_done_out(ost_done));

  // ----------------------------------------------------------------------
  // bus and comparison tasks
  // ----------------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic w;
    @(posedge core_clk_in);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge core_clk_in);
      w  = waitrequest;
      rd = readdata;
    end while (w);
    req <= '0;
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic do_reset();
    reset_in         <= 1'b1;
    power_up_done_in <= 1'b0;
    osc_on           <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    reset_in <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    rd_chk(TSSCM_ADDR_CONFIG, 32'h0);
    rd_chk(TSSCM_ADDR_OSC_CONTROL, 32'h0);
    rd_chk(TSSCM_ADDR_IRQ_CLEAR, 32'h0);
    rd_chk(4'hF, 32'h0);
    check(use_internal, 32'h1);
    // switchover off: power-up must not pass through the start-up phase
    wrt(TSSCM_ADDR_IRQ_ENABLE, 32'h7);
    power_up_done_in <= 1'b1;
    osc_on           <= 1'b1;
    while (!ost_done) @(posedge core_clk_in);
    repeat (10) @(posedge core_clk_in);
    bus(1'b0, TSSCM_ADDR_IRQ_STATUS, 32'h0);
    check(rd & 32'h4, 32'h0);
    rd_chk(TSSCM_ADDR_OSC_CONTROL, 32'h8);
    // second reset, then two-speed start-up on a crystal primary
    do_reset();
    wrt(TSSCM_ADDR_CONFIG, 32'h1);
    wrt(TSSCM_ADDR_IRQ_ENABLE, 32'h4);
    power_up_done_in <= 1'b1;
    osc_on           <= 1'b1;
    repeat (6) @(negedge core_clk_in);
    check(use_internal, 32'h1);
    check(irq, 32'h1);
    rd_chk(TSSCM_ADDR_IRQ_STATUS, 32'h4);
    rd_chk(TSSCM_ADDR_OSC_CONTROL, 32'h0);
    wrt(TSSCM_ADDR_OSC_CONTROL, 32'h2);
    rd_chk(TSSCM_ADDR_OSC_CONTROL, 32'h2);
    wrt(TSSCM_ADDR_OSC_CONTROL, 32'h0);
    wrt(TSSCM_ADDR_IRQ_CLEAR, 32'h4);
    wrt(TSSCM_ADDR_IRQ_ENABLE, 32'h1);
    @(negedge core_clk_in);
    check(irq, 32'h0);
    while (!ost_done) @(posedge core_clk_in);
    repeat (8) @(negedge core_clk_in);
    check(use_internal, 32'h0);
    check(primary_run, 32'h1);
    check(irq, 32'h1);
    rd_chk(TSSCM_ADDR_OSC_CONTROL, 32'h8);
    wrt(TSSCM_ADDR_IRQ_ENABLE, 32'h0);
    @(negedge core_clk_in);
    check(irq, 32'h0);
    rd_chk(TSSCM_ADDR_IRQ_STATUS, 32'h1);
    wrt(TSSCM_ADDR_IRQ_CLEAR, 32'h1);
    // second pass sleeps again before the start-up timer has expired
    for (int i = 0; i < 2; i++) begin
      wrt(TSSCM_ADDR_CONTROL, 32'h1);
      repeat (4) @(negedge core_clk_in);
      check(sleep_st, 32'h1);
      @(posedge core_clk_in);
      wake_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      wake_in <= 1'b0;
      repeat (5) @(negedge core_clk_in);
      check(sleep_st, 32'h0);
      check(use_internal, 32'h1);
    end
    while (!ost_done) @(posedge core_clk_in);
    repeat (8) @(negedge core_clk_in);
    check(use_internal, 32'h0);
    // fail-safe monitor: healthy clock first, then a frozen primary
    wrt(TSSCM_ADDR_CONFIG, 32'h2);
    wrt(TSSCM_ADDR_IRQ_CLEAR, 32'h7);
    wrt(TSSCM_ADDR_IRQ_ENABLE, 32'h2);
    repeat (600) @(negedge core_clk_in);
    check(rc_run, 32'h1);
    check(use_internal, 32'h0);
    check(irq, 32'h0);
    @(posedge core_clk_in);
    osc_stop <= 1'b1;
    for (int i = 0; i < 800 && !irq; i++) @(negedge core_clk_in);
    check(irq, 32'h1);
    // clock output is registered one cycle behind the status bit
    @(negedge core_clk_in);
    check(use_internal, 32'h1);
    wrt(TSSCM_ADDR_IRQ_STATUS, 32'h0);
    rd_chk(TSSCM_ADDR_IRQ_STATUS, 32'h2);
    rd_chk(TSSCM_ADDR_OSC_CONTROL, 32'h10);
    osc_stop <= 1'b0;
    wrt(TSSCM_ADDR_CONTROL, 32'h2);
    wrt(TSSCM_ADDR_IRQ_CLEAR, 32'h2);
    repeat (6) @(negedge core_clk_in);
    check(use_internal, 32'h0);
    check(irq, 32'h0);
    results();
  end
endmodule // testbench
`default_nettype wire
